//--- bench/cidt_decoder_asserts.sv
// Purpose: concurrent checks on the decoder ports
// Assumes: one clock, synchronous active-high reset
// Notes:   flush checks hold whether or not the fetch side keeps words ready
`timescale 1ns/10ps
module cidt_decoder_chk (
  input wire       core_clk,
  input wire       reset,
  input wire       fetch_ready,
  input wire       dec_valid,
  input wire       dec_nop,
  input wire       pc_change,
  input wire       inst_done,
  input wire [1:0] inst_cycles,
  input wire [3:0] dec_class,
  input wire [7:0] dec_opcode,
  input wire       dec_two_word
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  wire [7:0] op = dec_opcode;
  wire one_c = (op >= 8'h10 && op <= 8'hce) || op >= 8'he0;
  wire stall = op == 8'h0b || op == 8'h0c || (op >= 8'hd0 && op <= 8'hdf);
  wire dbl = op == 8'h02 || op == 8'h04 || op == 8'hcf;
  // ----------------------------------------
  // multi-step tails
  // ----------------------------------------
  sequence s_flush;
    dec_nop && inst_done && inst_cycles == 2'd2;
  endsequence
  sequence s_ret;
    dec_nop && !inst_done ##1 dec_nop && inst_done && inst_cycles == 2'd3;
  endsequence
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_nop_alone: assert property (dec_nop |-> !dec_valid)
    else $error("nop and valid pulse together");
  a_class_onehot: assert property (dec_valid |-> $onehot(dec_class))
    else $error("class not one-hot");
  a_single_one: assert property (dec_valid && one_c |-> inst_done && inst_cycles == 2'd1)
    else $error("plain op not one cycle");
  a_stall_two: assert property (dec_valid && stall |-> !fetch_ready
    ##1 (fetch_ready && inst_done && inst_cycles == 2'h2))
    else $error("table or double move timing");
  a_two_word_set: assert property (dec_valid |-> dec_two_word == dbl)
    else $error("two-word flag wrong");
  a_two_cycles: assert property (dec_valid && dec_two_word |-> inst_done && inst_cycles == 2'd2)
    else $error("two-word op not two cycles");
  a_long_redirect: assert property (dec_valid && (op == 8'h02 || op == 8'h04) |-> pc_change)
    else $error("long jump without redirect");
  a_jump_flush: assert property (dec_valid && pc_change &&
    (op == 8'h01 || op == 8'h05 || op == 8'h06) |-> !inst_done ##1 s_flush)
    else $error("jump flush cycle wrong");
  a_return_three: assert property (dec_valid && (op == 8'h09 || op == 8'h0a) |-> pc_change ##1 s_ret)
    else $error("return not three cycles");
  a_cond_false: assert property (dec_valid && op == 8'h05 && !pc_change |-> inst_done && inst_cycles == 2'd1)
    else $error("untaken branch not one cycle");
endmodule // cidt_decoder_chk

bind cidt_decoder cidt_decoder_chk u_cidt_decoder_chk (.core_clk(core_clk), .reset(reset),
  .fetch_ready(fetch_ready), .dec_valid(dec_valid), .dec_nop(dec_nop), .pc_change(pc_change),
  .inst_done(inst_done), .inst_cycles(inst_cycles), .dec_class(dec_class), .dec_opcode(dec_opcode),
  .dec_two_word(dec_two_word));

//--- bench/cidt_progmem.sv
// Purpose: program memory fetch model
// Assumes: the bench queues words in program order
// Notes:   idle data toggles so a stale word never looks fresh
`timescale 1ns/10ps
module cidt_progmem (
  input  wire         core_clk,
  input  wire         fetch_ready,
  output logic        fetch_valid,
  output logic [23:0] fetch_word
);
  logic [23:0] q[$];
  logic        taken = 1'b0;
  initial fetch_valid = 1'b0;
  initial fetch_word = 24'h0;
  task push(input logic [23:0] w);
    q.push_back(w);
  endtask
  always @(posedge core_clk) taken <= fetch_valid & fetch_ready;
  // word held until taken; next one after the falling edge
  always @(negedge core_clk) begin
    if (taken || !fetch_valid) begin
      fetch_valid <= q.size() > 0;
      fetch_word <= q.size() > 0 ? q.pop_front() : ~fetch_word;
    end
  end
endmodule // cidt_progmem

//--- bench/tb.sv
// Purpose: self-checking bench for the decoder
// Assumes: words come from the fetch model, conditions set at falling edge
// Notes:   fields checked after completion, so pads are only flush words
`timescale 1ns/10ps
module tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic cond_true = 1'b0;
  logic skip_true = 1'b0;
  int errors = 0;
  int n_tests = 0;
  logic se;
  wire [23:0] fw;
  wire fv, fr, dv, we, idn, dwz, bi;
  wire [1:0] ic, ssm, tm;
  wire [3:0] cls, bsr, ssr, rdr, bs;
  wire [12:0] rlo;
  wire [15:0] lv;
  wire [22:0] ta;
  wire [1:0] rdm;
  wire bwf, lsd;
  always #4 core_clk = ~core_clk;
  cidt_progmem u_cidt_progmem (.core_clk(core_clk), .fetch_ready(fr), .fetch_valid(fv), .fetch_word(fw));
  cidt_decoder u_cidt_decoder (.core_clk(core_clk), .reset(reset), .fetch_word(fw), .fetch_valid(fv),
    .fetch_ready(fr), .cond_true(cond_true), .skip_true(skip_true), .dec_valid(dv), .dec_nop(),
    .pc_change(), .second_word_err(we), .inst_done(idn), .inst_cycles(ic), .dec_class(cls),
    .dec_opcode(), .dec_two_word(), .base_source_register(bsr), .second_source_register(ssr),
    .second_source_mode(ssm), .result_destination_register(rdr), .result_destination_mode(rdm),
    .reg_location_operand(rlo), .dest_working_register_zero(dwz), .bit_select(bs), .bit_indirect(bi),
    .bit_working_register_zero_form(bwf), .literal_separate_dest(lsd), .literal_value(lv), .target_address(ta), .table_mode(tm));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task close_out;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task chk(input bit ok, input string m);
    n_tests++;
    if (!ok) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // queue n words, wait for completion, compare count and decode pulse
  task automatic run(input [23:0] a, b, c, input int n, input [1:0] ec, input ev);
    logic sv;
    sv = 1'b0;
    se = 1'b0;
    u_cidt_progmem.push(a);
    if (n > 1) u_cidt_progmem.push(b);
    if (n > 2) u_cidt_progmem.push(c);
    for (int k = 0; k < 20; k++) begin
      @(negedge core_clk);
      sv = sv | dv;
      se = se | we;
      if (idn === 1'b1) break;
    end
    chk(idn === 1'b1 && ic === ec && sv === ev, "cycle count or decode pulse");
    repeat (2) @(negedge core_clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reg;
    run({8'h10, 4'ha, 2'h2, 4'h5, 2'h1, 4'h3}, 24'h0, 24'h0, 1, 2'd1, 1'b1);
    chk(cls === 4'h1 && bsr === 4'ha && ssm === 2'h2 && ssr === 4'h5 && rdr === 4'h3, "reg form");
    chk(rdm === 2'h1, "destination mode");
  endtask
  task t_file;
    run({8'h60, 16'h3fff}, 24'h0, 24'h0, 1, 2'd1, 1'b1);
    chk(rlo === 13'h1fff && dwz === 1'b0, "file top address");
    run({8'h7f, 16'h0000}, 24'h0, 24'h0, 1, 2'd1, 1'b1);
    chk(rlo === 13'h0 && dwz === 1'b1, "file to working zero");
  endtask
  task t_bit;
    run({8'h80, 16'hf4a0}, 24'h0, 24'h0, 1, 2'h1, 1'b1);
    chk(cls === 4'h2 && bi === 1'b1 && bs === 4'hd && bwf === 1'b1, "bit form");
  endtask
  task t_lit;
    run({8'ha0, 16'h5a80}, 24'h0, 24'h0, 1, 2'd1, 1'b1);
    chk(cls === 4'h4 && bsr === 4'h5 && rdr === 4'h5 && lv === 16'h0015, "literal arith");
    chk(lsd === 1'b0, "literal shared dest flag");
    run({8'ha0, 16'h5ac7}, 24'h0, 24'h0, 1, 2'h1, 1'b1);
    chk(rdr === 4'h7 && lsd === 1'b1 && lv === 16'h0015, "literal separate dest");
    run({8'hc0, 16'hbeef}, 24'h0, 24'h0, 1, 2'd1, 1'b1);
    chk(lv === 16'h0bee, "literal move");
  endtask
  task t_ctl;
    logic [7:0] op [9];
    int pd [9];
    int cy [9];
    op = '{8'h01, 8'h06, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'hd0, 8'h05, 8'h05};
    pd = '{1, 1, 2, 2, 0, 0, 0, 0, 1};
    cy = '{2, 2, 3, 3, 2, 2, 2, 1, 2};
    for (int k = 0; k < 9; k++) begin
      cond_true = k == 8;
      run({op[k], 16'h0003}, 24'h0, 24'h0, pd[k] + 1, cy[k][1:0], 1'b1);
      if (k == 4) chk(tm === 2'h3 && cls === 4'h8, "table mode");
    end
    cond_true = 1'b0;
  endtask
  task t_two;
    run({8'h04, 16'h1234}, {8'h00, 16'h0056}, 24'h0, 2, 2'd2, 1'b1);
    chk(ta === 23'h561234 && se === 1'b0, "long target");
    run({8'hcf, 16'h0000}, {8'h00, 16'hcafe}, 24'h0, 2, 2'd2, 1'b1);
    chk(lv === 16'hcafe, "long literal");
    run({8'h02, 16'h0000}, {8'h5a, 16'h0000}, 24'h0, 2, 2'd2, 1'b1);
    chk(se === 1'b1, "bad second word not flagged");
  endtask
  task t_lone;
    run({8'h00, 16'h1234}, 24'h0, 24'h0, 1, 2'd1, 1'b0);
  endtask
  task t_skip;
    skip_true = 1'b1;
    run({8'h0d, 16'h0}, {8'h10, 16'h0}, 24'h0, 2, 2'd2, 1'b1);
    run({8'h0d, 16'h0}, {8'h04, 16'h0}, 24'h0, 3, 2'd3, 1'b1);
    skip_true = 1'b0;
    run({8'h0d, 16'h0}, 24'h0, 24'h0, 1, 2'h1, 1'b1);
  endtask
  initial begin
    #20000;
    errors++;
    close_out;
  end
  initial begin
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    chk(cls === 4'h0 && fr === 1'b1 && dv === 1'b0, "reset state");
    t_reg;
    t_file;
    t_bit;
    t_lit;
    t_ctl;
    t_two;
    t_lone;
    t_skip;
    close_out;
  end
endmodule // tb

//--- src/cidt_consts.vh
// Purpose: constants for the instruction decode and cycle-timing block
// Assumes: 24-bit program words, opcode in the top byte
// Notes:   opcode values and operand bit layouts are local to this core
`ifndef CIDT_CONSTS_VH
`define CIDT_CONSTS_VH

// ----------------------------------------------------------------------
// word fields (msb:lsb)
// ----------------------------------------------------------------------
`define CIDT_F_OPC     23:16
`define CIDT_F_BASE    15:12
`define CIDT_F_WSM     11:10
`define CIDT_F_WS      9:6
`define CIDT_F_WDM     5:4
`define CIDT_F_WD      3:0
`define CIDT_F_FADDR   12:0
`define CIDT_B_FDEST   13
`define CIDT_B_BWFORM  15
`define CIDT_B_BIND    14
`define CIDT_F_BITLIT  13:10
`define CIDT_F_BFADDR  9:0
`define CIDT_F_BBASE   7:4
`define CIDT_F_LIT5    11:7
`define CIDT_B_DSEP    6
`define CIDT_F_LIT12   15:4
`define CIDT_F_LOW16   15:0
`define CIDT_F_TBLMODE 1:0
`define CIDT_F_HI7     6:0

// ----------------------------------------------------------------------
// opcodes and category ranges
// ----------------------------------------------------------------------
`define CIDT_OP_NOP    8'h00
`define CIDT_OP_UBRA   8'h01
`define CIDT_OP_CALLL  8'h02
`define CIDT_OP_JMPL   8'h04
`define CIDT_OP_CBRA   8'h05
`define CIDT_OP_INDIR  8'h06
`define CIDT_OP_RET    8'h09
`define CIDT_OP_RETI   8'h0a
`define CIDT_OP_TBLRD  8'h0b
`define CIDT_OP_TBLWR  8'h0c
`define CIDT_OP_SKIP   8'h0d
`define CIDT_OP_MOVL   8'hcf
`define CIDT_OP_WB_LO  8'h10
`define CIDT_OP_FR_LO  8'h60
`define CIDT_OP_BIT_LO 8'h80
`define CIDT_OP_LA_LO  8'ha0
`define CIDT_OP_LM_LO  8'hc0
`define CIDT_OP_DM_LO  8'hd0
`define CIDT_OP_DM_HI  8'hdf

// ----------------------------------------------------------------------
// one-hot categories, reset values
// ----------------------------------------------------------------------
`define CIDT_CLS_WB    4'h1
`define CIDT_CLS_BIT   4'h2
`define CIDT_CLS_LIT   4'h4
`define CIDT_CLS_CTL   4'h8
`define CIDT_HI8_ZERO  8'h00
`define CIDT_RST_CLS   4'h0

`endif

//--- src/cidt_decoder.v
// Purpose: instruction decode and cycle timing for a 16-bit core
// Assumes: fetch path and condition inputs share core_clk
// Notes:   extra cycles read a second word, discard fetched words or hold the fetch
`timescale 1ns/10ps
`include "cidt_consts.vh"

// How it works
// - 24-bit words, 8-bit opcode, operands below
// - only three opcodes span two words
// - second word top byte zero, 48 bits total
// - lone second word runs as no-op
// - plain single-word instruction takes one cycle
// - taken condition or pc change: two cycles, three for returns
// - jumps, calls, tables, returns take two/three
// - taken skip: two or three cycles
// - double-word moves take two cycles
// - two-word instructions take two cycles
// - register form: base, source, destination operands
// - file form: address plus destination select
// - bit form: location plus literal/indirect selector
// - literal arith: base, literal, optional destination
// - literal move: literal into register/location
// - control: program address or table mode
// - four one-hot instruction categories
// - file address spans zero to 1fff
module cidt_decoder (
  input  wire        core_clk,
  input  wire        reset,
  input  wire [23:0] fetch_word,
  input  wire        fetch_valid,
  output wire        fetch_ready,
  input  wire        cond_true,
  input  wire        skip_true,
  output wire        dec_valid,
  output wire        dec_nop,
  output wire        pc_change,
  output wire        second_word_err,
  output wire        inst_done,
  output wire [1:0]  inst_cycles,
  output wire [3:0]  dec_class,
  output wire [7:0]  dec_opcode,
  output wire        dec_two_word,
  output wire [3:0]  base_source_register,
  output wire [3:0]  second_source_register,
  output wire [1:0]  second_source_mode,
  output wire [3:0]  result_destination_register,
  output wire [1:0]  result_destination_mode,
  output wire [12:0] reg_location_operand,
  output wire        dest_working_register_zero,
  output wire [3:0]  bit_select,
  output wire        bit_indirect,
  output wire        bit_working_register_zero_form,
  output wire        literal_separate_dest,
  output wire [15:0] literal_value,
  output wire [22:0] target_address,
  output wire [1:0]  table_mode
);

  // --------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------
  localparam [6:0] S_EXEC   = 7'h01;
  localparam [6:0] S_WORD2  = 7'h02;
  localparam [6:0] S_FLUSH1 = 7'h04;
  localparam [6:0] S_FLUSH2 = 7'h08;
  localparam [6:0] S_HOLD   = 7'h10;
  localparam [6:0] S_SKIP   = 7'h20;
  localparam [6:0] S_SKIP2  = 7'h40;

  reg  [6:0]  state_reg;
  reg  [1:0]  cnt_reg;
  reg         dec_valid_reg;
  reg         dec_nop_reg;
  reg         pc_change_reg;
  reg         err_reg;
  reg         done_reg;
  reg  [1:0]  cycles_reg;
  reg  [3:0]  class_reg;
  reg  [7:0]  opcode_reg;
  reg         two_reg;
  reg  [3:0]  base_reg;
  reg  [3:0]  ws_reg;
  reg  [1:0]  wsm_reg;
  reg  [3:0]  wd_reg;
  reg  [1:0]  wdm_reg;
  reg  [12:0] faddr_reg;
  reg         fwreg_reg;
  reg  [3:0]  bitsel_reg;
  reg         bind_reg;
  reg         bwform_reg;
  reg         dsep_reg;
  reg  [15:0] lit_reg;
  reg  [22:0] target_reg;
  reg  [1:0]  tmode_reg;

  // --------------------------------------------------------------------
  // combinational decode of the presented word
  // --------------------------------------------------------------------
  wire [7:0] op      = fetch_word[`CIDT_F_OPC];
  wire       is_ctl  = op < `CIDT_OP_WB_LO;
  wire       is_fr   = (op >= `CIDT_OP_FR_LO) && (op < `CIDT_OP_BIT_LO);
  wire       is_bit  = (op >= `CIDT_OP_BIT_LO) && (op < `CIDT_OP_LA_LO);
  wire       is_la   = (op >= `CIDT_OP_LA_LO) && (op < `CIDT_OP_LM_LO);
  wire       is_lm   = (op >= `CIDT_OP_LM_LO) && (op < `CIDT_OP_DM_LO);
  wire       is_dm   = (op >= `CIDT_OP_DM_LO) && (op <= `CIDT_OP_DM_HI);
  wire       is_two  = (op == `CIDT_OP_CALLL) || (op == `CIDT_OP_JMPL) ||
                       (op == `CIDT_OP_MOVL);
  wire       is_fl1  = (op == `CIDT_OP_UBRA) || (op == `CIDT_OP_INDIR) ||
                       ((op == `CIDT_OP_CBRA) && cond_true);
  wire       is_ret  = (op == `CIDT_OP_RET) || (op == `CIDT_OP_RETI);
  wire       is_hold = (op == `CIDT_OP_TBLRD) || (op == `CIDT_OP_TBLWR) || is_dm;
  wire       dsep    = fetch_word[`CIDT_B_DSEP];

  reg  [3:0]  cls_next;
  reg  [3:0]  wd_next;
  reg  [12:0] faddr_next;
  reg  [15:0] lit_next;

  always @* begin
    cls_next = `CIDT_CLS_WB;
    if (is_ctl)
      cls_next = `CIDT_CLS_CTL;
    else if (is_bit)
      cls_next = `CIDT_CLS_BIT;
    else if (is_la || is_lm)
      cls_next = `CIDT_CLS_LIT;
    wd_next = fetch_word[`CIDT_F_WD];
    if (is_la && !dsep)
      wd_next = fetch_word[`CIDT_F_BASE];
    // bit form only reaches the low part of data space
    faddr_next = {3'h0, fetch_word[`CIDT_F_BFADDR]};
    if (is_fr)
      faddr_next = fetch_word[`CIDT_F_FADDR];
    lit_next = {11'h000, fetch_word[`CIDT_F_LIT5]};
    if (is_lm)
      lit_next = {4'h0, fetch_word[`CIDT_F_LIT12]};
  end

  // --------------------------------------------------------------------
  // sequencing and field capture
  // --------------------------------------------------------------------
  // hold stalls fetch; flush cycles still take the word and drop it
  assign fetch_ready = (state_reg != S_HOLD);

  always @(posedge core_clk) begin
    if (reset) begin
      state_reg     <= S_EXEC;
      cnt_reg       <= 2'h0;
      dec_valid_reg <= 1'b0;
      dec_nop_reg   <= 1'b0;
      pc_change_reg <= 1'b0;
      err_reg       <= 1'b0;
      done_reg      <= 1'b0;
      cycles_reg    <= 2'h0;
      class_reg     <= `CIDT_RST_CLS;
      opcode_reg    <= `CIDT_OP_NOP;
      two_reg       <= 1'b0;
      base_reg      <= 4'h0;
      ws_reg        <= 4'h0;
      wsm_reg       <= 2'h0;
      wd_reg        <= 4'h0;
      wdm_reg       <= 2'h0;
      faddr_reg     <= 13'h0000;
      fwreg_reg     <= 1'b0;
      bitsel_reg    <= 4'h0;
      bind_reg      <= 1'b0;
      bwform_reg    <= 1'b0;
      dsep_reg      <= 1'b0;
      lit_reg       <= 16'h0000;
      target_reg    <= 23'h000000;
      tmode_reg     <= 2'h0;
    end else begin
      dec_valid_reg <= 1'b0;
      dec_nop_reg   <= 1'b0;
      pc_change_reg <= 1'b0;
      err_reg       <= 1'b0;
      done_reg      <= 1'b0;
      case (state_reg)
        S_EXEC: begin
          if (fetch_valid) begin
            cnt_reg    <= 2'h1;
            class_reg  <= cls_next;
            opcode_reg <= op;
            two_reg    <= is_two;
            base_reg   <= fetch_word[`CIDT_F_BASE];
            ws_reg     <= fetch_word[`CIDT_F_WS];
            wsm_reg    <= fetch_word[`CIDT_F_WSM];
            wd_reg     <= wd_next;
            wdm_reg    <= fetch_word[`CIDT_F_WDM];
            faddr_reg  <= faddr_next;
            fwreg_reg  <= ~fetch_word[`CIDT_B_FDEST];
            bitsel_reg <= fetch_word[`CIDT_F_BITLIT];
            bind_reg   <= fetch_word[`CIDT_B_BIND];
            bwform_reg <= fetch_word[`CIDT_B_BWFORM];
            dsep_reg   <= dsep;
            lit_reg    <= lit_next;
            target_reg <= {7'h00, fetch_word[`CIDT_F_LOW16]};
            tmode_reg  <= fetch_word[`CIDT_F_TBLMODE];
            if (op == `CIDT_OP_NOP) begin
              dec_nop_reg <= 1'b1;
              done_reg    <= 1'b1;
              cycles_reg  <= 2'h1;
            end else if (is_two) begin
              state_reg <= S_WORD2;
            end else begin
              dec_valid_reg <= 1'b1;
              if (is_fl1) begin
                pc_change_reg <= 1'b1;
                state_reg     <= S_FLUSH1;
              end else if (is_ret) begin
                pc_change_reg <= 1'b1;
                state_reg     <= S_FLUSH2;
              end else if (is_hold) begin
                state_reg <= S_HOLD;
              end else if ((op == `CIDT_OP_SKIP) && skip_true) begin
                state_reg <= S_SKIP;
              end else begin
                done_reg   <= 1'b1;
                cycles_reg <= 2'h1;
              end
            end
          end
        end
        S_WORD2: begin
          if (fetch_valid) begin
            target_reg[22:16] <= fetch_word[`CIDT_F_HI7];
            if (opcode_reg == `CIDT_OP_MOVL)
              lit_reg <= fetch_word[`CIDT_F_LOW16];
            err_reg       <= (fetch_word[`CIDT_F_OPC] != `CIDT_HI8_ZERO);
            dec_valid_reg <= 1'b1;
            pc_change_reg <= (opcode_reg != `CIDT_OP_MOVL);
            done_reg      <= 1'b1;
            cycles_reg    <= 2'h2;
            state_reg     <= S_EXEC;
          end
        end
        S_FLUSH2: begin
          dec_nop_reg <= 1'b1;
          cnt_reg     <= cnt_reg + 2'h1;
          state_reg   <= S_FLUSH1;
        end
        S_FLUSH1: begin
          // word fetched before the redirect is dropped here
          dec_nop_reg <= 1'b1;
          done_reg    <= 1'b1;
          cycles_reg  <= cnt_reg + 2'h1;
          state_reg   <= S_EXEC;
        end
        S_HOLD: begin
          done_reg   <= 1'b1;
          cycles_reg <= 2'h2;
          state_reg  <= S_EXEC;
        end
        S_SKIP: begin
          if (fetch_valid) begin
            dec_nop_reg <= 1'b1;
            if (is_two) begin
              cnt_reg   <= 2'h2;
              state_reg <= S_SKIP2;
            end else begin
              done_reg   <= 1'b1;
              cycles_reg <= 2'h2;
              state_reg  <= S_EXEC;
            end
          end
        end
        S_SKIP2: begin
          if (fetch_valid) begin
            dec_nop_reg <= 1'b1;
            done_reg    <= 1'b1;
            cycles_reg  <= 2'h3;
            state_reg   <= S_EXEC;
          end
        end
        default: begin
          state_reg <= S_EXEC;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign dec_valid                   = dec_valid_reg;
  assign dec_nop                     = dec_nop_reg;
  assign pc_change                   = pc_change_reg;
  assign second_word_err             = err_reg;
  assign inst_done                   = done_reg;
  assign inst_cycles                 = cycles_reg;
  assign dec_class                   = class_reg;
  assign dec_opcode                  = opcode_reg;
  assign dec_two_word                = two_reg;
  assign base_source_register        = base_reg;
  assign second_source_register      = ws_reg;
  assign second_source_mode          = wsm_reg;
  assign result_destination_register = wd_reg;
  assign result_destination_mode     = wdm_reg;
  assign reg_location_operand        = faddr_reg;
  assign dest_working_register_zero  = fwreg_reg;
  assign bit_select                  = bitsel_reg;
  assign bit_indirect                = bind_reg;
  assign bit_working_register_zero_form               = bwform_reg;
  assign literal_separate_dest       = dsep_reg;
  assign literal_value               = lit_reg;
  assign target_address              = target_reg;
  assign table_mode                  = tmode_reg;

endmodule // cidt_decoder
